// ==== scc_defs.svh ====
/*
  register indices, field positions, reset values and timing counts
  of the symbol counter control block.
  assumes: included by bare name by every design file that needs it.
*/
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH
// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define SCC_IDX_CTRL_A    8'hDC
`define SCC_IDX_CTRL_B    8'hDD
`define SCC_IDX_STATUS    8'hDE
`define SCC_IDX_MASK      8'hDF
`define SCC_IDX_FLAGS     8'hE0
`define SCC_IDX_COUNT     8'hE1
`define SCC_IDX_BEACON_TS 8'hE2
`define SCC_IDX_FRAME_TS  8'hE3
`define SCC_IDX_CMP1      8'hE4
`define SCC_IDX_CMP2      8'hE5
`define SCC_IDX_CMP3      8'hE6
// ----------------------------------------
// control a fields
// ----------------------------------------
`define SCC_A_SYNC   7
`define SCC_A_MTS    6
`define SCC_A_EN     5
`define SCC_A_CKSEL  4
`define SCC_A_TSE    3
// control b fields
`define SCC_B_BTSM   5
`define SCC_B_DIV_HI 4
`define SCC_B_DIV_LO 2
`define SCC_B_EXT    1
`define SCC_B_BOEN   0
// flag / mask fields
`define SCC_F_BO     4
`define SCC_F_OF     3
`define SCC_F_MSB    4
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define SCC_RST_BYTE    8'h00
`define SCC_RST_WORD    32'h0000_0000
`define SCC_CNT_MAX     32'hFFFF_FFFF
`define SCC_BO_LAST     5'h13
`define SCC_LOAD_MAX_NS 16000
`define SCC_CLK_NS      50
`define SCC_LOAD_CYC    (`SCC_LOAD_MAX_NS / `SCC_CLK_NS)
`endif

// ==== scc_pkg.sv ====
/*
  types of the symbol counter control block.
  assumes: compiled before any module of the block.
*/
package scc_pkg;
  // counter time base, one-hot
  typedef enum logic [2:0] {
    SCC_SRC_XTAL = 3'h1,
    SCC_SRC_RTC  = 3'h2,
    SCC_SRC_EXT  = 3'h4
  } scc_src_type;
endpackage : scc_pkg

// ==== scc_pin_sync.sv ====
/*
  two flip-flop synchroniser with rising edge pulse per bit.
  assumes: inputs are asynchronous pins; one clock, sync reset.
*/
`timescale 1ns/1ps
`default_nettype none
module scc_pin_sync #(
  parameter int W = 3
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] rise_r
);
  logic [W-1:0] meta_r;  // first stage, read only by the second
  logic [W-1:0] sync_r;  // second stage
  logic [W-1:0] prev_r;  // delayed copy for edge detect

  // ---------------------------------------
  // synchroniser and edge detector
  // ---------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      rise_r <= '0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      rise_r <= sync_r & ~prev_r;
    end
  end
endmodule : scc_pin_sync
`default_nettype wire

// ==== scc_prescaler.sv ====
/*
  crystal clock prescaler: divides crystal edges by 256 down to 4.
  assumes: xtal_edge is a one-cycle pulse per crystal rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scc_defs.svh"
module scc_prescaler (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       xtal_edge,
  input  wire logic       clear,
  input  wire logic [2:0] div_code,
  output logic            tick_r
);
  logic [7:0] pre_r;  // free divider count

  // mask of low bits for the selected divisor, 256 >> code
  function automatic logic [7:0] div_mask(input logic [2:0] code);
    div_mask = 8'hFF >> code;  // R10
    if (code == 3'h7) begin
      div_mask = 8'hFF;  // reserved code falls back to the default
    end
  endfunction : div_mask

  // ---------------------------------------
  // divider; clear realigns the symbol period
  // ---------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst || clear) begin
      pre_r  <= 8'h00;  // R01
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (xtal_edge) begin
        pre_r  <= pre_r + 8'h01;
        tick_r <= (pre_r & div_mask(div_code)) == div_mask(div_code);
      end
    end
  end
endmodule : scc_prescaler
`default_nettype wire

// ==== scc_symbol_counter.sv ====
/*
  symbol counter control: time base select, 32-bit counter, backoff
  slots, timestamps, three compare units, flags and masks, reached
  over an avalon-mm slave with one wait cycle per access.
  assumes: radio events and sleep come from logic on clk_sys; the
  crystal, rtc and external clocks arrive as pins well below clk_sys.
*/
// Behaviour
// R01 - sync bit clears prescaler and backoff, self-clears
// R02 - alignment only holds on crystal time base
// R03 - manual stamp copies counter to beacon stamp
// R04 - disable stops counting, ignores counter writes
// R05 - clock select one picks rtc, zero crystal
// R06 - sleep forces rtc, wake restores selection
// R07 - auto stamps need auto timestamp enable
// R08 - compare absolute, or relative to beacon stamp
// R09 - beacon mask blocks only automatic beacon stamps
// R10 - divider codes 0..6 give 256 down to 4
// R11 - external pin clock overrides all, kept slow
// R12 - backoff runs with enable, irq needs mask
// R13 - busy from low byte write until loaded
// R14 - software avoids counter while busy
// R15 - flag clears on service or write one
// R16 - backoff flag every twenty symbols
// R17 - overflow flag on wrap to zero
// R18 - compare units set flag bits 0..2
// R19 - masked events still set flags
// R20 - software clears flag before enabling mask
// R21 - mask bits 4 backoff, 3 overflow, 2..0 compare
// R22 - reserved bits written zero, read as zero
// R23 - irq high while flag and mask set
`timescale 1ns/1ps
`default_nettype none
`include "scc_defs.svh"
module scc_symbol_counter (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  // avalon-mm slave, word index address
  input  wire logic [7:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  // clock pins
  input  wire logic               crystal_pin,
  input  wire logic               rtc_osc_pin,
  input  wire logic               ext_clock_pin,
  // radio side and interrupt service
  input  wire logic               transceiver_sleep,
  input  wire logic               frame_delim_evt,
  input  wire logic               beacon_evt,
  input  wire logic [4:0]         irq_serviced,
  // interrupt requests and active time base
  output logic                    backoff_interrupt,
  output logic                    overflow_interrupt,
  output logic [2:0]              match_interrupt,
  output var scc_pkg::scc_src_type active_source_r
);
  import scc_pkg::*;

  // ---------------------------------------
  // declarations
  // ---------------------------------------
  logic [5:0]  ctrl_a_r;        // enable, select, tse, modes
  logic [5:0]  ctrl_b_r;        // mask, divider, ext, boen
  logic [4:0]  mask_r;          // irq_mask_reg
  logic [4:0]  flags_r;         // irq_flag_reg
  logic [4:0]  flags_nxt;
  logic [31:0] count_r;         // count_value
  logic [31:0] count_nxt;
  logic [31:0] load_val_r;      // pending counter write
  logic        busy_r;          // update_busy
  logic [8:0]  load_wait_r;     // bounds the update time
  logic [31:0] beacon_ts_r;     // beacon timestamp
  logic [31:0] frame_ts_r;      // frame delimiter timestamp
  logic [31:0] cmp_r [3];       // unit compare values
  logic [4:0]  bo_cnt_r;        // backoff slot counter
  logic        sync_pulse_r;    // sync_clear, one cycle
  logic        mts_pulse_r;     // manual_timestamp, one cycle
  logic [2:0]  rise;            // synchronised pin edges
  logic        xtal_tick;       // prescaled crystal tick
  logic        tick;            // selected time base tick
  logic        run;             // counter running
  logic        acc;             // access completes this edge
  logic        wr_acc;
  logic        count_wr;
  logic        bo_evt;
  logic        of_evt;
  logic [2:0]  cmp_evt;
  logic [4:0]  clr;
  scc_src_type src;

  wire logic counter_enable        = ctrl_a_r[`SCC_A_EN];
  wire logic clock_select          = ctrl_a_r[`SCC_A_CKSEL];
  wire logic auto_timestamp_enable = ctrl_a_r[`SCC_A_TSE];
  wire logic beacon_stamp_mask     = ctrl_b_r[`SCC_B_BTSM];
  wire logic external_pin_clock    = ctrl_b_r[`SCC_B_EXT];
  wire logic backoff_enable        = ctrl_b_r[`SCC_B_BOEN];

  // fill a word with bytes enabled by the master
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction : merge

  // ---------------------------------------
  // time base
  // ---------------------------------------
  // pins pass two flops before any edge logic sees them
  scc_pin_sync #(.W(3)) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pin_in  ({ext_clock_pin, rtc_osc_pin, crystal_pin}),
    .rise_r  (rise)
  );

  // prescaler is reset by sys_rst and by the sync bit, on the crystal path only
  scc_prescaler u_pre (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .xtal_edge (rise[0]),
    .clear     (sync_pulse_r),
    .div_code  (ctrl_b_r[`SCC_B_DIV_HI:`SCC_B_DIV_LO]),
    .tick_r    (xtal_tick)
  );

  // source priority: external pin, then sleep or select, then crystal
  always_comb begin
    if (external_pin_clock) begin
      src = SCC_SRC_EXT;   // R11
    end else if (transceiver_sleep || clock_select) begin
      src = SCC_SRC_RTC;   // R05 R06
    end else begin
      src = SCC_SRC_XTAL;  // R05
    end
  end

  // rtc edges bypass the prescaler, so alignment does not carry over
  always_comb begin
    unique case (src)
      SCC_SRC_EXT:  tick = rise[2];
      SCC_SRC_RTC:  tick = rise[1];   // R02
      SCC_SRC_XTAL: tick = xtal_tick;
    endcase
  end

  assign run = counter_enable & tick;  // R04

  // reports which time base is in use
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      active_source_r <= SCC_SRC_XTAL;
    end else begin
      active_source_r <= src;
    end
  end

  // ---------------------------------------
  // bus decode
  // ---------------------------------------
  // each access waits exactly one cycle
  assign acc    = (avs_read || avs_write) && !avs_waitrequest;
  assign wr_acc = acc && avs_write;
  // counter writes are dropped while disabled
  assign count_wr = wr_acc && (avs_address == `SCC_IDX_COUNT)
                    && counter_enable;  // R04

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // read data is ready at the edge that ends the wait cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_readdata <= `SCC_RST_WORD;
    end else if (avs_read && avs_waitrequest) begin
      // reserved bits read as zero; self-clearing bits read zero
      unique case (avs_address)
        `SCC_IDX_CTRL_A:    avs_readdata <= {26'h0, ctrl_a_r};
        `SCC_IDX_CTRL_B:    avs_readdata <= {26'h0, ctrl_b_r};   // R22
        `SCC_IDX_STATUS:    avs_readdata <= {31'h0, busy_r};     // R13
        `SCC_IDX_MASK:      avs_readdata <= {27'h0, mask_r};
        `SCC_IDX_FLAGS:     avs_readdata <= {27'h0, flags_r};
        `SCC_IDX_COUNT:     avs_readdata <= count_r;
        `SCC_IDX_BEACON_TS: avs_readdata <= beacon_ts_r;
        `SCC_IDX_FRAME_TS:  avs_readdata <= frame_ts_r;
        `SCC_IDX_CMP1:      avs_readdata <= cmp_r[0];
        `SCC_IDX_CMP2:      avs_readdata <= cmp_r[1];
        `SCC_IDX_CMP3:      avs_readdata <= cmp_r[2];
        default:            avs_readdata <= `SCC_RST_WORD;
      endcase
    end
  end

  // ---------------------------------------
  // control registers
  // ---------------------------------------
  // only lane 0 carries the byte-wide registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_a_r     <= 6'(`SCC_RST_BYTE);
      ctrl_b_r     <= 6'(`SCC_RST_BYTE);
      mask_r       <= 5'(`SCC_RST_BYTE);
      sync_pulse_r <= 1'b0;
      mts_pulse_r  <= 1'b0;
    end else begin
      sync_pulse_r <= 1'b0;  // R01
      mts_pulse_r  <= 1'b0;  // R03
      if (wr_acc && avs_byteenable[0]) begin
        unique case (avs_address)
          `SCC_IDX_CTRL_A: begin
            ctrl_a_r     <= avs_writedata[5:0];
            sync_pulse_r <= avs_writedata[`SCC_A_SYNC];  // R01
            mts_pulse_r  <= avs_writedata[`SCC_A_MTS];   // R03
          end
          `SCC_IDX_CTRL_B: ctrl_b_r <= avs_writedata[5:0];  // R22
          `SCC_IDX_MASK:   mask_r   <= avs_writedata[4:0];  // R21
          default: ;
        endcase
      end
    end
  end

  // compare values accept any byte lane
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < 3; i++) begin
        cmp_r[i] <= `SCC_RST_WORD;
      end
    end else if (wr_acc) begin
      for (int i = 0; i < 3; i++) begin
        if (avs_address == `SCC_IDX_CMP1 + 8'(i)) begin
          cmp_r[i] <= merge(cmp_r[i], avs_writedata, avs_byteenable);
        end
      end
    end
  end

  // ---------------------------------------
  // counter and pending load
  // ---------------------------------------
  // a write is held until the next tick or the update time bound
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      busy_r      <= 1'b0;
      load_val_r  <= `SCC_RST_WORD;
      load_wait_r <= 9'h000;
    end else if (count_wr) begin
      load_val_r  <= merge(load_val_r, avs_writedata, avs_byteenable);
      if (avs_byteenable[0]) begin
        busy_r      <= 1'b1;  // R13
        load_wait_r <= 9'h000;
      end
    end else if (busy_r) begin
      load_wait_r <= load_wait_r + 9'h001;
      if (run || load_wait_r == 9'(`SCC_LOAD_CYC - 1) || !counter_enable) begin
        busy_r <= 1'b0;  // R13
      end
    end
  end

  // increment on each tick; a pending load replaces the step
  always_comb begin
    count_nxt = count_r;
    if (busy_r && counter_enable &&
        (run || load_wait_r == 9'(`SCC_LOAD_CYC - 1))) begin
      count_nxt = load_val_r;  // R13
    end else if (run) begin
      count_nxt = count_r + 32'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_r <= `SCC_RST_WORD;
    end else begin
      count_r <= count_nxt;
    end
  end

  // ---------------------------------------
  // timestamps
  // ---------------------------------------
  // manual stamps ignore both the enable and the beacon mask
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      beacon_ts_r <= `SCC_RST_WORD;
      frame_ts_r  <= `SCC_RST_WORD;
    end else begin
      if (mts_pulse_r) begin
        beacon_ts_r <= count_r;  // R03 R09
      end else if (beacon_evt && auto_timestamp_enable && !beacon_stamp_mask) begin
        beacon_ts_r <= count_r;  // R07 R09
      end
      if (frame_delim_evt && auto_timestamp_enable) begin
        frame_ts_r <= count_r;   // R07
      end
    end
  end

  // ---------------------------------------
  // backoff slot counter
  // ---------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst || sync_pulse_r) begin
      bo_cnt_r <= 5'h00;  // R01
    end else if (run && backoff_enable) begin
      bo_cnt_r <= (bo_cnt_r == `SCC_BO_LAST) ? 5'h00 : bo_cnt_r + 5'h01;  // R12 R16
    end
  end

  assign bo_evt = run && backoff_enable && (bo_cnt_r == `SCC_BO_LAST);  // R16

  // ---------------------------------------
  // events
  // ---------------------------------------
  assign of_evt = run && !busy_r && (count_r == `SCC_CNT_MAX);  // R17

  // match on the value the counter steps into
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (ctrl_a_r[i]) begin
        cmp_evt[i] = run && (count_nxt == beacon_ts_r + cmp_r[i]);  // R08
      end else begin
        cmp_evt[i] = run && (count_nxt == cmp_r[i]);                // R08
      end
    end
  end

  // ---------------------------------------
  // flags and interrupt requests
  // ---------------------------------------
  // write one clears, service of an enabled request clears
  always_comb begin
    clr = (irq_serviced & mask_r);  // R15
    if (wr_acc && avs_byteenable[0] && avs_address == `SCC_IDX_FLAGS) begin
      clr = clr | avs_writedata[4:0];  // R15
    end
    // events set flags regardless of mask, and win over clears
    flags_nxt = (flags_r & ~clr) | {bo_evt, of_evt, cmp_evt};  // R18 R19
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_r <= 5'(`SCC_RST_BYTE);
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // requests follow flag and mask, a late mask fires at once
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      backoff_interrupt  <= 1'b0;
      overflow_interrupt <= 1'b0;
      match_interrupt    <= 3'h0;
    end else begin
      backoff_interrupt  <= flags_r[`SCC_F_BO] & mask_r[`SCC_F_BO];  // R12 R21 R23
      overflow_interrupt <= flags_r[`SCC_F_OF] & mask_r[`SCC_F_OF];  // R21 R23
      match_interrupt    <= flags_r[2:0] & mask_r[2:0];              // R19 R23
    end
  end
endmodule : scc_symbol_counter
`default_nettype wire

// ==== scc_symbol_counter_sva.sv ====
/*
  checker for the symbol counter control block: bus handshake,
  time base choice, mask readback and interrupt gating.
  assumes: sees only the top module ports; bound at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module scc_symbol_counter_sva (
  input wire logic                 clk_sys,
  input wire logic                 sys_rst,
  input wire logic [7:0]           avs_address,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_writedata,
  input wire logic [3:0]           avs_byteenable,
  input wire logic [31:0]          avs_readdata,
  input wire logic                 avs_waitrequest,
  input wire logic                 transceiver_sleep,
  input wire logic [4:0]           irq_serviced,
  input wire logic                 backoff_interrupt,
  input wire logic                 overflow_interrupt,
  input wire logic [2:0]           match_interrupt,
  input wire scc_pkg::scc_src_type active_source_r
);
  import scc_pkg::*;
  // ----------
  // shadow copies of the fields the checks depend on
  // ----------
  logic [4:0]  msk_r;   // mask copy
  logic        cksel_r; // clock select copy
  logic        ext_r;   // pin clock copy
  scc_src_type exp_src; // expected time base
  wire         wr_hit = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire [4:0]   irq_v  = {backoff_interrupt, overflow_interrupt, match_interrupt};
  // mask copy follows accepted writes only
  always_ff @(posedge clk_sys) begin
    if (sys_rst) msk_r <= 5'h00;
    else if (wr_hit && avs_address == 8'hDF) msk_r <= avs_writedata[4:0];
  end
  // clock select copy
  always_ff @(posedge clk_sys) begin
    if (sys_rst) cksel_r <= 1'b0;
    else if (wr_hit && avs_address == 8'hDC) cksel_r <= avs_writedata[4];
  end
  // pin clock copy
  always_ff @(posedge clk_sys) begin
    if (sys_rst) ext_r <= 1'b0;
    else if (wr_hit && avs_address == 8'hDD) ext_r <= avs_writedata[1];
  end
  // pin clock beats sleep, sleep beats the select bit
  always_comb exp_src = ext_r ? SCC_SRC_EXT : (cksel_r || transceiver_sleep) ? SCC_SRC_RTC : SCC_SRC_XTAL;
  // ----------
  // sequences and assertions
  // ----------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_take;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_mask_rd;
    avs_read && avs_waitrequest && avs_address == 8'hDF ##1 !avs_waitrequest;
  endsequence
  sequence s_bad_rd;
    avs_read && avs_waitrequest && (avs_address < 8'hDC || avs_address > 8'hE6) ##1 !avs_waitrequest;
  endsequence
  sequence s_flag_w1c;
    avs_write && avs_waitrequest && avs_address == 8'hE0 && avs_byteenable[0] && avs_writedata[4] ##1 !avs_waitrequest;
  endsequence
  chk_wait_take: assert property (s_take |=> !avs_waitrequest)
    else $error("access not answered in one cycle");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_src_select: assert property (
    exp_src == $past(exp_src) && $past(exp_src) == $past(exp_src, 2) |-> active_source_r == exp_src)
    else $error("time base differs from select, sleep and pin clock");
  chk_mask_read: assert property (s_mask_rd |-> avs_readdata == {27'h0, msk_r})
    else $error("mask readback wrong");
  chk_unmapped_read: assert property (s_bad_rd |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_irq_masked: assert property ((irq_v & ~$past(msk_r)) == 5'h00)
    else $error("interrupt raised with its mask clear");
  chk_service_clr: assert property (irq_serviced[3] && overflow_interrupt |-> ##2 !overflow_interrupt)
    else $error("serviced overflow interrupt stays high");
  chk_w1c_clear: assert property (s_flag_w1c |-> ##2 !backoff_interrupt)
    else $error("write one did not drop backoff interrupt");
endmodule : scc_symbol_counter_sva
bind scc_symbol_counter scc_symbol_counter_sva scc_symbol_counter_sva_i (.*);
`default_nettype wire

// ==== scc_symbol_counter_bench.sv ====
/*
  self-checking bench for the symbol counter control block.
  assumes: design and checker compiled first; 50 ns clock.
*/
`timescale 1ns/1ps
`default_nettype none
module scc_symbol_counter_bench;
  import scc_pkg::*;
  // ----------
  // signals and model
  // ----------
  logic        clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic        crystal_pin, rtc_osc_pin, ext_clock_pin, transceiver_sleep;
  logic        frame_delim_evt, beacon_evt, backoff_interrupt, overflow_interrupt;
  logic [7:0]  avs_address, ph;
  logic [31:0] avs_writedata, avs_readdata, q, c, b;
  logic [3:0]  avs_byteenable;
  logic [4:0]  irq_serviced;
  logic [2:0]  match_interrupt;
  scc_src_type active_source_r;
  int          error_cnt, checks;
  logic [31:0] mdl [int];                                               // expected readback per index
  logic [7:0]  ra [6] = '{8'hDC, 8'hDD, 8'hDF, 8'hE4, 8'hE5, 8'hE6};    // read-write registers
  scc_symbol_counter scc_symbol_counter_i (.*);
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // slow pins: crystal period 4 cycles, pin clock 8 cycles, rtc 64
  always @(posedge clk_sys) begin
    ph            <= ph + 8'h01;
    crystal_pin   <= ph[1];
    ext_clock_pin <= ph[2];
    rtc_osc_pin   <= ph[5];
  end
  // ----------
  // tasks
  // ----------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // read-write bits per index, zero elsewhere; self-clearing control bits read zero
  function automatic logic [31:0] msk(input logic [7:0] a);
    case (a)
      8'hDC, 8'hDD:        msk = 32'h3F;
      8'hDF:               msk = 32'h1F;
      8'hE4, 8'hE5, 8'hE6: msk = 32'hFFFF_FFFF;
      default:             msk = 32'h0;
    endcase
  endfunction : msk
  // one bus access, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    chk({31'h0, avs_waitrequest}, 32'h0);
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
    mdl[a] = d & msk(a);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rc
  // one-cycle radio event: frame delimiter when f, else beacon
  task automatic evt(input logic f);
    @(posedge clk_sys);
    frame_delim_evt <= f;
    beacon_evt      <= !f;
    @(posedge clk_sys);
    frame_delim_evt <= 1'b0;
    beacon_evt      <= 1'b0;
  endtask : evt
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask : fin
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  // watchdog: the whole sequence needs well under 10000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    summarize;
  end
  // ----------
  // main sequence
  // ----------
  initial begin
    {avs_read, avs_write, transceiver_sleep, frame_delim_evt, beacon_evt} = 5'h00;
    {crystal_pin, rtc_osc_pin, ext_clock_pin} = 3'h0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    irq_serviced = 5'h00;
    ph = 8'h00;
    error_cnt = 0;
    checks = 0;
    sys_rst = 1'b1;
    c = $urandom(76);
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int a = 8'hDC; a <= 8'hE6; a++) rc(a[7:0], 32'h0);
    rc(8'hFF, 32'h0);
    fin("reset");
    foreach (ra[k]) begin
      wr(ra[k], $urandom & msk(ra[k]));
      rc(ra[k], mdl[ra[k]]);
    end
    foreach (ra[k]) wr(ra[k], 32'h0);
    fin("readback");
    acc(1'b0, 8'hE1, 32'h0);
    c = q;
    wr(8'hE1, 32'h1234_5678);
    rc(8'hE1, c);
    fin("disabled");
    // sync parks the slow prescaler, so the 320 cycle cap loads first
    wr(8'hDC, 32'hA0);
    wr(8'hE1, 32'hFFFF_FFFE);
    rc(8'hDE, 32'h1);
    repeat (150) begin
      acc(1'b0, 8'hDE, 32'h0);
      if (q[0] === 1'b0) break;
    end
    chk({31'h0, q[0]}, 32'h0);
    rc(8'hE1, 32'hFFFF_FFFE);
    wr(8'hE0, 32'h1F);
    wr(8'hDF, 32'h08);
    wr(8'hDD, 32'h18);
    for (int i = 0; i < 3000 && overflow_interrupt !== 1'b1; i++) @(posedge clk_sys);
    chk({31'h0, overflow_interrupt}, 32'h1);
    rc(8'hE0, 32'h0F);
    @(posedge clk_sys);
    irq_serviced <= 5'h08;
    @(posedge clk_sys);
    irq_serviced <= 5'h00;
    repeat (2) @(posedge clk_sys);
    chk({31'h0, overflow_interrupt}, 32'h0);
    rc(8'hE0, 32'h07);
    wr(8'hE0, 32'h07);
    rc(8'hE0, 32'h0);
    wr(8'hDF, 32'h0);
    fin("overflow");
    // divide by 4 of a 4 cycle crystal: one symbol per 16 cycles
    wr(8'hDD, 32'h19);
    wr(8'hDC, 32'hA0);
    wr(8'hE0, 32'h1F);
    repeat (260) @(posedge clk_sys);
    rc(8'hE0, 32'h0);
    repeat (110) @(posedge clk_sys);
    rc(8'hE0, 32'h10);
    wr(8'hDF, 32'h10);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, backoff_interrupt}, 32'h1);
    wr(8'hE0, 32'h10);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, backoff_interrupt}, 32'h0);
    wr(8'hDF, 32'h0);
    wr(8'hDD, 32'h18);
    wr(8'hE0, 32'h1F);
    repeat (400) @(posedge clk_sys);
    rc(8'hE0, 32'h0);
    fin("backoff");
    wr(8'hDC, 32'h62);
    acc(1'b0, 8'hE2, 32'h0);
    b = q;
    wr(8'hE5, 32'd20);
    wr(8'hE4, b + 32'd40);
    wr(8'hE6, b + 32'd5000);
    repeat (900) @(posedge clk_sys);
    rc(8'hE0, 32'h03);
    wr(8'hDF, 32'h02);
    repeat (2) @(posedge clk_sys);
    chk({29'h0, match_interrupt}, 32'h2);
    wr(8'hDF, 32'h0);
    fin("compare");
    wr(8'hDC, 32'h0);
    acc(1'b0, 8'hE1, 32'h0);
    c = q;
    evt(1'b1);
    rc(8'hE3, 32'h0);
    wr(8'hDC, 32'h08);
    evt(1'b1);
    rc(8'hE3, c);
    wr(8'hDD, 32'h20);
    evt(1'b0);
    rc(8'hE2, b);
    wr(8'hDC, 32'h48);
    rc(8'hE2, c);
    fin("stamps");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      transceiver_sleep <= i[0];
      wr(8'hDC, {27'h0, i[1], 4'h0});
      wr(8'hDD, {30'h0, i[2], 1'b0});
      repeat (4) @(posedge clk_sys);
      chk({29'h0, active_source_r}, {29'h0, i[2] ? SCC_SRC_EXT : (i[1] | i[0]) ? SCC_SRC_RTC : SCC_SRC_XTAL});
    end
    fin("source");
    summarize;
  end
endmodule : scc_symbol_counter_bench
`default_nettype wire
